// *** verilog/sdpr_pkg.sv ***
/*
 Constants shared by both ends of the synthesizer register link:
 frame layout, register addresses, field positions, divider limits,
 serial timing and the controller's own register map.
 Assumes a single 10 MHz core clock at both ends.
*/
`default_nettype none
package sdpr_pkg;
   // Serial frame: address nibble first, then data, both MSB first
   localparam logic [4:0] FRAME_LEN = 5'h16;

   // Device register addresses
   localparam logic [3:0] ADDR_POWER = 4'h2;
   localparam logic [3:0] ADDR_RF1_N = 4'h3;
   localparam logic [3:0] ADDR_RF2_N = 4'h4;
   localparam logic [3:0] ADDR_IF_N = 4'h5;
   localparam logic [3:0] ADDR_RF1_R = 4'h6;
   localparam logic [3:0] ADDR_RF2_R = 4'h7;
   localparam logic [3:0] ADDR_IF_R = 4'h8;
   localparam logic [3:0] ADDR_RSVD_LO = 4'h9;

   // Field positions
   localparam int PWR_IF_BIT = 1;
   localparam int PWR_RF_BIT = 0;

   // Reset values: dividers and enables start at zero
   localparam logic RST_SYNTH_ON = 1'b0;
   localparam logic [17:0] RST_DIV = 18'h00000;

   // Divider limits
   localparam logic [17:0] RF1N_MIN = 18'h003e0;
   localparam logic [17:0] RF2N_MIN = 18'h000f0;
   localparam logic [17:0] IFN_MIN = 18'h00038;
   localparam logic [12:0] RDIV_MAX = 13'h1ffd;
   localparam logic [12:0] RMIN_G0 = 13'h0007;
   localparam logic [12:0] RMIN_G1 = 13'h0008;
   localparam logic [12:0] RMIN_G2 = 13'h000a;
   localparam logic [12:0] RMIN_G3 = 13'h000e;
   localparam logic [17:0] GAIN_STEP1 = 18'h01000;
   localparam logic [17:0] GAIN_STEP2 = 18'h02000;
   localparam logic [17:0] GAIN_STEP3 = 18'h04000;

   // Serial clock half period: 400 ns in core clock cycles
   localparam logic [3:0] SCLK_HALF_CYC = 4'h4;

   // Controller register map (AXI4-Lite byte addresses)
   localparam logic [3:0] REG_DATA = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_GAIN = 4'hc;
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_RF1G_LO = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Least reference divider allowed for a detector gain code
   function automatic logic [12:0] refMin(input logic [1:0] gain);
      case (gain)
         2'h0: refMin = RMIN_G0;
         2'h1: refMin = RMIN_G1;
         2'h2: refMin = RMIN_G2;
         default: refMin = RMIN_G3;
      endcase
   endfunction : refMin

   // RF1 detector gain code implied by the RF1 feedback divider
   function automatic logic [1:0] gainFromN(input logic [17:0] n);
      if (n < GAIN_STEP1) begin
         gainFromN = 2'h0;
      end else if (n < GAIN_STEP2) begin
         gainFromN = 2'h1;
      end else if (n < GAIN_STEP3) begin
         gainFromN = 2'h2;
      end else begin
         gainFromN = 2'h3;
      end
   endfunction : gainFromN
endpackage : sdpr_pkg
`default_nettype wire

// *** verilog/sdpr_serial_if.sv ***
/*
 Three-wire serial link between the controller and the synthesizer
 register bank. All wires are driven by the controller only and
 change on the shared core clock.
*/
`default_nettype none
interface sdpr_serial_if;
   logic serialEnable;  // Active high frame gate
   logic serialClk;     // Data sampled on its rising edge
   logic serialDataIn;  // Address then data, MSB first

   modport host (output serialEnable, output serialClk, output serialDataIn);
   modport device (input serialEnable, input serialClk, input serialDataIn);
endinterface : sdpr_serial_if
`default_nettype wire

// *** verilog/sdpr_device.sv ***
/*
 Synthesizer register bank, write side: powerdown enables and the
 feedback and reference dividers of the RF1, RF2 and IF loops,
 loaded from 22-bit serial frames.
 Assumes serial pins are synchronous to core_clk and the serial clock
 half period spans at least two core clock cycles.
*/
`default_nettype none
module sdpr_device (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Serial link
   sdpr_serial_if.device link,
   // Main configuration input
   input wire logic autoPowerdown,
   // Synthesizer controls
   output logic ifSynthOn,
   output logic rfSynthOn,
   output logic [17:0] rf1FeedbackDivider,
   output logic [16:0] rf2FeedbackDivider,
   output logic [15:0] ifFeedbackDivider,
   output logic [12:0] rf1ReferenceDivider,
   output logic [12:0] rf2ReferenceDivider,
   output logic [12:0] ifReferenceDivider
);
   logic sclkPrevQ;
   logic enPrevQ;
   logic [21:0] shiftQ;
   logic [4:0] cntQ;
   logic [1:0] powerQ;
   logic commit;
   logic [3:0] frameAddr;
   logic [17:0] frameData;

   // Edge history of the serial pins
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sclkPrevQ <= 1'b0;
         enPrevQ <= 1'b0;
      end else begin
         sclkPrevQ <= link.serialClk;
         enPrevQ <= link.serialEnable;
      end
   end

   // RULE15 shift while enabled
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         shiftQ <= 22'h000000;
         cntQ <= 5'h00;
      end else if (!link.serialEnable) begin
         cntQ <= 5'h00;
      end else if (link.serialClk && !sclkPrevQ) begin
         shiftQ <= {shiftQ[20:0], link.serialDataIn};
         // Saturate so an overlong frame is never committed
         if (cntQ != 5'h1f) begin
            cntQ <= cntQ + 5'h01;
         end
      end
   end

   // RULE15 commit at frame end
   // A short or long frame is dropped whole rather than half applied
   assign commit = enPrevQ && !link.serialEnable && (cntQ == sdpr_pkg::FRAME_LEN);
   assign frameAddr = shiftQ[21:18];
   assign frameData = shiftQ[17:0];

   // RULE1 RULE2 powerdown enables
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         powerQ <= {2{sdpr_pkg::RST_SYNTH_ON}};
      end else if (commit && frameAddr == sdpr_pkg::ADDR_POWER) begin
         powerQ <= {frameData[sdpr_pkg::PWR_IF_BIT], frameData[sdpr_pkg::PWR_RF_BIT]};
      end
   end

   // RULE12 auto powerdown overrides
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ifSynthOn <= sdpr_pkg::RST_SYNTH_ON;
         rfSynthOn <= sdpr_pkg::RST_SYNTH_ON;
      end else begin
         ifSynthOn <= autoPowerdown | powerQ[1];
         rfSynthOn <= autoPowerdown | powerQ[0];
      end
   end

   // RULE3 RULE4 RULE5 feedback dividers
   // Upper bits the host must zero are simply not stored
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rf1FeedbackDivider <= sdpr_pkg::RST_DIV;
         rf2FeedbackDivider <= sdpr_pkg::RST_DIV[16:0];
         ifFeedbackDivider <= sdpr_pkg::RST_DIV[15:0];
      end else if (commit) begin
         if (frameAddr == sdpr_pkg::ADDR_RF1_N) begin
            rf1FeedbackDivider <= frameData;
         end
         if (frameAddr == sdpr_pkg::ADDR_RF2_N) begin
            rf2FeedbackDivider <= frameData[16:0];
         end
         if (frameAddr == sdpr_pkg::ADDR_IF_N) begin
            ifFeedbackDivider <= frameData[15:0];
         end
      end
   end

   // RULE6 RULE8 RULE10 reference dividers
   // Addresses 0, 1 and 9 to 15 touch nothing in this bank
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rf1ReferenceDivider <= sdpr_pkg::RST_DIV[12:0];
         rf2ReferenceDivider <= sdpr_pkg::RST_DIV[12:0];
         ifReferenceDivider <= sdpr_pkg::RST_DIV[12:0];
      end else if (commit) begin
         if (frameAddr == sdpr_pkg::ADDR_RF1_R) begin
            rf1ReferenceDivider <= frameData[12:0];
         end
         if (frameAddr == sdpr_pkg::ADDR_RF2_R) begin
            rf2ReferenceDivider <= frameData[12:0];
         end
         if (frameAddr == sdpr_pkg::ADDR_IF_R) begin
            ifReferenceDivider <= frameData[12:0];
         end
      end
   end
endmodule : sdpr_device
`default_nettype wire

// *** verilog/sdpr_host.sv ***
/*
 Controller end of the synthesizer link: an AXI4-Lite slave holding
 a data word, a command register, status and gain settings, and a
 serial engine that sends checked 22-bit frames to the register bank.
 Assumes one AXI master with at most one write and one read in flight.
*/
// Notes on behaviour
// RULE1: IF synthesizer bit one, on when set
// RULE2: RF bit zero; reserved bits sent zero
// RULE3: RF1 feedback divider at least 992
// RULE4: RF2 feedback: bit 17 zero, min 240
// RULE5: IF feedback: bits 17:16 zero, min 56
// RULE6: RF1 reference bits 17:13 sent zero
// RULE7: RF1 reference within gain bound and 8189
// RULE8: RF2 reference upper five bits zero
// RULE9: RF2 reference within gain bound and 8189
// RULE10: IF reference bits 17:13 sent zero
// RULE11: IF reference bound uses RF1 gain code
// RULE12: Auto powerdown forces both synthesizers on
// RULE13: RF1 gain code follows RF1 feedback divider
// RULE14: Never send to addresses nine to fifteen
// RULE15: Register updates only at frame completion
`default_nettype none
module sdpr_host (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // AXI4-Lite write address
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Serial link
   sdpr_serial_if.host link
);
   typedef enum logic [2:0] {
      SDPR_IDLE = 3'b001,
      SDPR_SHIFT = 3'b010,
      SDPR_FINISH = 3'b100
   } sdpr_state_t;

   sdpr_state_t stateQ;
   logic awHeldQ;
   logic wHeldQ;
   logic [3:0] awAddrQ;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;
   logic [17:0] dataQ;
   logic [1:0] rf2GainQ;
   logic [1:0] rf1GainQ;
   logic refusedQ;
   logic [21:0] frameQ;
   logic [4:0] bitCntQ;
   logic [3:0] tickCntQ;
   logic doWrite;
   logic cmdWrite;
   logic startSend;
   logic setRefused;
   logic clrRefused;
   logic tick;
   logic busy;
   logic [3:0] cmdAddr;

   // Frame check before anything is sent
   function automatic logic frameOk(input logic [3:0] a, input logic [17:0] d,
                                    input logic [1:0] g1, input logic [1:0] g2);
      case (a)
         // RULE2 reserved bits zero
         sdpr_pkg::ADDR_POWER: frameOk = (d[17:2] == 16'h0000);
         // RULE3 RF1 feedback minimum
         sdpr_pkg::ADDR_RF1_N: frameOk = (d >= sdpr_pkg::RF1N_MIN);
         // RULE4 RF2 feedback limits
         sdpr_pkg::ADDR_RF2_N: frameOk = !d[17] && (d >= sdpr_pkg::RF2N_MIN);
         // RULE5 IF feedback limits
         sdpr_pkg::ADDR_IF_N: frameOk = (d[17:16] == 2'h0) && (d >= sdpr_pkg::IFN_MIN);
         // RULE6 RULE7 RF1 reference range
         sdpr_pkg::ADDR_RF1_R: frameOk = (d[17:13] == 5'h00)
            && (d[12:0] >= sdpr_pkg::refMin(g1)) && (d[12:0] <= sdpr_pkg::RDIV_MAX);
         // RULE8 RULE9 RF2 reference range
         sdpr_pkg::ADDR_RF2_R: frameOk = (d[17:13] == 5'h00)
            && (d[12:0] >= sdpr_pkg::refMin(g2)) && (d[12:0] <= sdpr_pkg::RDIV_MAX);
         // RULE10 RULE11 IF reference bound from RF1 gain
         sdpr_pkg::ADDR_IF_R: frameOk = (d[17:13] == 5'h00)
            && (d[12:0] >= sdpr_pkg::refMin(g1)) && (d[12:0] <= sdpr_pkg::RDIV_MAX);
         4'h0, 4'h1: frameOk = 1'b1;
         // RULE14 reserved addresses refused
         default: frameOk = 1'b0;
      endcase
   endfunction : frameOk

   // Write accepted once both address and data have arrived
   assign doWrite = awHeldQ && wHeldQ && !bvalid;
   assign cmdWrite = doWrite && (awAddrQ == sdpr_pkg::REG_CMD) && wStrbQ[0];
   assign cmdAddr = wDataQ[3:0];
   assign busy = (stateQ != SDPR_IDLE);
   assign startSend = cmdWrite && !busy && frameOk(cmdAddr, dataQ, rf1GainQ, rf2GainQ);
   assign setRefused = cmdWrite && !startSend;
   assign clrRefused = doWrite && (awAddrQ == sdpr_pkg::REG_STATUS)
                       && wStrbQ[0] && wDataQ[sdpr_pkg::ST_REFUSED];

   // Write address and data channels, taken in either order
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         awHeldQ <= 1'b0;
         wHeldQ <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         awAddrQ <= 4'h0;
         wDataQ <= 32'h00000000;
         wStrbQ <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awHeldQ <= 1'b1;
            awready <= 1'b0;
            awAddrQ <= awaddr;
         end
         if (wvalid && wready) begin
            wHeldQ <= 1'b1;
            wready <= 1'b0;
            wDataQ <= wdata;
            wStrbQ <= wstrb;
         end
         if (bvalid && bready) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Write response; a refused command still answers OKAY, see status
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         bvalid <= 1'b0;
         bresp <= sdpr_pkg::RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp <= (awAddrQ[1:0] == 2'h0) ? sdpr_pkg::RESP_OKAY : sdpr_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Data word and RF2 gain setting, honouring byte strobes
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         dataQ <= sdpr_pkg::RST_DIV;
         rf2GainQ <= 2'h0;
      end else if (doWrite) begin
         if (awAddrQ == sdpr_pkg::REG_DATA) begin
            if (wStrbQ[0]) dataQ[7:0] <= wDataQ[7:0];
            if (wStrbQ[1]) dataQ[15:8] <= wDataQ[15:8];
            if (wStrbQ[2]) dataQ[17:16] <= wDataQ[17:16];
         end
         if (awAddrQ == sdpr_pkg::REG_GAIN && wStrbQ[0]) begin
            rf2GainQ <= wDataQ[1:0];
         end
      end
   end

   // RULE13 gain tracks last RF1 feedback sent
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rf1GainQ <= 2'h0;
      end else if (startSend && cmdAddr == sdpr_pkg::ADDR_RF1_N) begin
         rf1GainQ <= sdpr_pkg::gainFromN(dataQ);
      end
   end

   // Sticky refusal flag; a new refusal beats a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         refusedQ <= 1'b0;
      end else begin
         refusedQ <= setRefused | (refusedQ & ~clrRefused);
      end
   end

   // Read channel, answered one cycle after the address is taken
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= sdpr_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= sdpr_pkg::RESP_OKAY;
         case (araddr)
            sdpr_pkg::REG_DATA: rdata <= {14'h0000, dataQ};
            sdpr_pkg::REG_CMD: rdata <= {28'h0000000, frameQ[21:18]};
            sdpr_pkg::REG_STATUS: rdata <= {28'h0000000, rf1GainQ, refusedQ, busy};
            sdpr_pkg::REG_GAIN: rdata <= {30'h00000000, rf2GainQ};
            default: begin
               rdata <= 32'h00000000;
               rresp <= sdpr_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Serial clock divider: one tick per half period while sending
   assign tick = (tickCntQ == sdpr_pkg::SCLK_HALF_CYC - 4'h1);
   always_ff @(posedge core_clk) begin
      if (!nrst || !busy || tick) begin
         tickCntQ <= 4'h0;
      end else begin
         tickCntQ <= tickCntQ + 4'h1;
      end
   end

   // RULE15 frame engine: enable, 22 clocks, then release
   // Data changes only while the serial clock is low
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stateQ <= SDPR_IDLE;
         frameQ <= 22'h000000;
         bitCntQ <= 5'h00;
         link.serialEnable <= 1'b0;
         link.serialClk <= 1'b0;
         link.serialDataIn <= 1'b0;
      end else begin
         case (stateQ)
            SDPR_IDLE: begin
               if (startSend) begin
                  frameQ <= {cmdAddr, dataQ};
                  bitCntQ <= 5'h00;
                  link.serialEnable <= 1'b1;
                  link.serialDataIn <= cmdAddr[3];
                  stateQ <= SDPR_SHIFT;
               end
            end
            SDPR_SHIFT: begin
               if (tick && !link.serialClk) begin
                  link.serialClk <= 1'b1;
               end else if (tick) begin
                  link.serialClk <= 1'b0;
                  frameQ <= {frameQ[20:0], frameQ[21]};
                  link.serialDataIn <= frameQ[20];
                  bitCntQ <= bitCntQ + 5'h01;
                  if (bitCntQ == sdpr_pkg::FRAME_LEN - 5'h01) begin
                     stateQ <= SDPR_FINISH;
                  end
               end
            end
            SDPR_FINISH: begin
               if (tick) begin
                  link.serialEnable <= 1'b0;
                  link.serialDataIn <= 1'b0;
                  stateQ <= SDPR_IDLE;
               end
            end
            default: stateQ <= SDPR_IDLE;
         endcase
      end
   end
endmodule : sdpr_host
`default_nettype wire

// *** testbench/sdpr_assertions.sv ***
/*
 Checker on the serial link between controller and register bank.
 Assumes link signals change only after core_clk edges; nrst is synchronous.
*/
`default_nettype none
module sdpr_assertions (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Serial link
   input wire logic serialEnable,
   input wire logic serialClk,
   input wire logic serialDataIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic clkPrev_q;
   logic [4:0] riseCnt_q;
   logic [21:0] frame_q;
   wire logic clkRise = serialClk && !clkPrev_q;
   wire logic [3:0] frameAddr = frame_q[21:18];
   wire logic [17:0] frameData = frame_q[17:0];

   // Frame capture, held for the end-of-frame checks
   always_ff @(posedge core_clk) begin
      clkPrev_q <= nrst && serialClk;
      if (!nrst || !serialEnable) begin
         riseCnt_q <= 5'h00;
      end else if (clkRise) begin
         riseCnt_q <= riseCnt_q + 5'h01;
      end
      if (!nrst) begin
         frame_q <= 22'h000000;
      end else if (clkRise && serialEnable) begin
         frame_q <= {frame_q[20:0], serialDataIn};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_clk_idle; !serialEnable |-> !serialClk; endproperty
   a_clk_idle: assert property (p_clk_idle) else $error("clock outside frame");
   property p_start; $rose(serialEnable) |-> !serialClk [*4] ##1 serialClk; endproperty
   a_start: assert property (p_start) else $error("bad frame start");
   property p_clk_high; $rose(serialClk) |-> serialClk [*4] ##1 !serialClk; endproperty
   a_clk_high: assert property (p_clk_high) else $error("bad high phase");
   property p_clk_low; $fell(serialClk) && serialEnable |-> !serialClk [*4]; endproperty
   a_clk_low: assert property (p_clk_low) else $error("bad low phase");
   property p_data_stable; serialClk |-> $stable(serialDataIn); endproperty
   a_data_stable: assert property (p_data_stable) else $error("data moved");
   property p_bit_count; $fell(serialEnable) |-> riseCnt_q == 5'h16; endproperty
   a_bit_count: assert property (p_bit_count) else $error("bit count wrong");
   property p_frame_len; $rose(serialEnable) |-> ##180 $fell(serialEnable); endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
   property p_addr_ok; $fell(serialEnable) |-> frameAddr < sdpr_pkg::ADDR_RSVD_LO; endproperty
   a_addr_ok: assert property (p_addr_ok) else $error("reserved address sent");
   property p_power; $fell(serialEnable) && frameAddr == sdpr_pkg::ADDR_POWER
      |-> frameData[17:2] == 16'h0000; endproperty
   a_power: assert property (p_power) else $error("power word not clean");
   property p_rf1n; $fell(serialEnable) && frameAddr == sdpr_pkg::ADDR_RF1_N
      |-> frameData >= sdpr_pkg::RF1N_MIN; endproperty
   a_rf1n: assert property (p_rf1n) else $error("rf1 feedback low");
   property p_rf2n; $fell(serialEnable) && frameAddr == sdpr_pkg::ADDR_RF2_N
      |-> !frameData[17] && frameData >= sdpr_pkg::RF2N_MIN; endproperty
   a_rf2n: assert property (p_rf2n) else $error("rf2 feedback bad");
   property p_ifn; $fell(serialEnable) && frameAddr == sdpr_pkg::ADDR_IF_N
      |-> frameData[17:16] == 2'h0 && frameData >= sdpr_pkg::IFN_MIN; endproperty
   a_ifn: assert property (p_ifn) else $error("if feedback bad");
   property p_rdiv; $fell(serialEnable) && frameAddr >= sdpr_pkg::ADDR_RF1_R
      && frameAddr <= sdpr_pkg::ADDR_IF_R |-> frameData[17:13] == 5'h00
      && frameData[12:0] >= sdpr_pkg::RMIN_G0 && frameData[12:0] <= sdpr_pkg::RDIV_MAX;
   endproperty
   a_rdiv: assert property (p_rdiv) else $error("reference word bad");
endmodule : sdpr_assertions
`default_nettype wire

// *** testbench/synth_divider_power_regs_test.sv ***
/*
 Self-checking bench: controller and register bank joined by the link.
 Assumes the controller map of sdpr_pkg and a 10 MHz core clock.
*/
`default_nettype none
module synth_divider_power_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   // Bench inputs; responses accepted at once
   logic core_clk = 1'b0, nrst = 1'b0, autoPowerdown = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
   // Design outputs and bench state
   logic awready, wready, bvalid, arready, rvalid, ifSynthOn, rfSynthOn, ok;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, st;
   logic [31:0] expReg [0:15] = '{default: 32'h00000000};
   logic [17:0] rf1N, d;
   logic [16:0] rf2N;
   logic [15:0] ifN;
   logic [12:0] rf1R, rf2R, ifR;
   logic [3:0] a;
   int fails = 0, checksDone = 0, cycles = 0;
   // Frames: accepted flag, address, data word
   logic [22:0] cases [0:27] = '{
      {1'b1, 4'h2, 18'h00002}, {1'b1, 4'h2, 18'h00001}, {1'b0, 4'h2, 18'h00005},
      {1'b1, 4'h3, 18'h003e0}, {1'b0, 4'h3, 18'h003df}, {1'b1, 4'h3, 18'h3ffff},
      {1'b1, 4'h4, 18'h1ffff}, {1'b1, 4'h4, 18'h000f0}, {1'b0, 4'h4, 18'h000ef},
      {1'b0, 4'h4, 18'h200f0}, {1'b1, 4'h5, 18'h0ffff}, {1'b1, 4'h5, 18'h00038},
      {1'b0, 4'h5, 18'h00037}, {1'b0, 4'h5, 18'h10038}, {1'b1, 4'h6, 18'h0000e},
      {1'b0, 4'h6, 18'h0000d}, {1'b1, 4'h6, 18'h01ffd}, {1'b0, 4'h6, 18'h01ffe},
      {1'b0, 4'h6, 18'h0200e}, {1'b1, 4'h7, 18'h0000a}, {1'b0, 4'h7, 18'h00009},
      {1'b0, 4'h7, 18'h01ffe}, {1'b0, 4'h7, 18'h0200a}, {1'b1, 4'h8, 18'h0000e},
      {1'b0, 4'h8, 18'h0000d}, {1'b0, 4'h8, 18'h0200e}, {1'b0, 4'h9, 18'h00000},
      {1'b0, 4'hf, 18'h00000}};
   // Feedback divider steps and implied gain codes
   logic [17:0] nVals [0:6] = '{18'h003e0, 18'h00fff, 18'h01000, 18'h01fff,
      18'h02000, 18'h03fff, 18'h04000};
   logic [1:0] gVals [0:6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};

   sdpr_serial_if link();
   sdpr_host i_sdpr_host (.core_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .link(link));
   sdpr_device i_sdpr_device (.core_clk, .nrst, .link(link), .autoPowerdown, .ifSynthOn,
      .rfSynthOn, .rf1FeedbackDivider(rf1N), .rf2FeedbackDivider(rf2N),
      .ifFeedbackDivider(ifN), .rf1ReferenceDivider(rf1R), .rf2ReferenceDivider(rf2R),
      .ifReferenceDivider(ifR));
   sdpr_assertions i_sdpr_assertions (.core_clk, .nrst, .serialEnable(link.serialEnable),
      .serialClk(link.serialClk), .serialDataIn(link.serialDataIn));

   // Clock; ceiling well above the ~4300 cycles needed
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         wrapUp();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wrapUp();
      if (fails == 0 && checksDone > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrapUp

   // Write: AW and W offered together, each dropped once taken
   task automatic axWr(input logic [3:0] ad, input logic [31:0] dt, output logic [1:0] rs);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= ad;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge core_clk);
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge core_clk); while (bvalid !== 1'b1);
      rs = bresp;
   endtask : axWr

   task automatic axRd(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] rs);
      araddr <= ad;
      arvalid <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      dt = rdata;
      rs = rresp;
   endtask : axRd

   task automatic sendReg(input logic [3:0] ad, input logic [17:0] dt);
      axWr(sdpr_pkg::REG_DATA, {14'h0000, dt}, r);
      axWr(sdpr_pkg::REG_CMD, {28'h0000000, ad}, r);
   endtask : sendReg

   // Poll until idle, then let the bank commit
   task automatic waitIdle();
      do axRd(sdpr_pkg::REG_STATUS, st, r); while (st[0] !== 1'b0);
      repeat (3) @(posedge core_clk);
   endtask : waitIdle

   function automatic logic [31:0] devOut(input logic [3:0] ad);
      case (ad)
         4'h2: devOut = {30'h0, ifSynthOn, rfSynthOn};
         4'h3: devOut = {14'h0, rf1N};
         4'h4: devOut = {15'h0, rf2N};
         4'h5: devOut = {16'h0, ifN};
         4'h6: devOut = {19'h0, rf1R};
         4'h7: devOut = {19'h0, rf2R};
         4'h8: devOut = {19'h0, ifR};
         default: devOut = 32'h00000000;
      endcase
   endfunction : devOut

   initial begin
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      // Bank starts cleared
      for (int i = 2; i < 9; i++) begin
         check(devOut(4'(i)), 32'h00000000);
      end
      // Controller registers, unmapped offsets refused
      axWr(sdpr_pkg::REG_DATA, 32'hffffffff, r);
      axRd(sdpr_pkg::REG_DATA, st, r);
      check(st, 32'h0003ffff);
      axWr(sdpr_pkg::REG_GAIN, 32'h00000002, r);
      axRd(sdpr_pkg::REG_GAIN, st, r);
      check(st, 32'h00000002);
      axWr(4'h2, 32'h00000001, r);
      check({30'h0, r}, {30'h0, sdpr_pkg::RESP_SLVERR});
      axRd(4'h6, st, r);
      check({st[29:0], r}, {30'h0, sdpr_pkg::RESP_SLVERR});
      // A frame lands whole; a refused one leaves the bank alone
      foreach (cases[i]) begin
         {ok, a, d} = cases[i];
         sendReg(a, d);
         waitIdle();
         if (ok) begin
            expReg[a] = {14'h0000, d};
         end
         check({31'h0, st[1]}, {31'h0, !ok});
         check(devOut(a), expReg[a]);
         axWr(sdpr_pkg::REG_STATUS, 32'h00000002, r);
      end
      // Command while busy is refused, running frame still lands
      sendReg(4'h4, 18'h00100);
      axWr(sdpr_pkg::REG_CMD, 32'h00000004, r);
      waitIdle();
      check({31'h0, st[1]}, 32'h00000001);
      check(devOut(4'h4), 32'h00000100);
      axWr(sdpr_pkg::REG_STATUS, 32'h00000002, r);
      // Gain code follows feedback divider; old value holds mid-frame
      foreach (nVals[i]) begin
         sendReg(4'h3, nVals[i]);
         repeat (60) @(posedge core_clk);
         check(devOut(4'h3), expReg[3]);
         waitIdle();
         expReg[3] = {14'h0000, nVals[i]};
         check(devOut(4'h3), expReg[3]);
         check({30'h0, st[3:2]}, {30'h0, gVals[i]});
      end
      // Auto powerdown overrides both enables
      sendReg(4'h2, 18'h00000);
      waitIdle();
      check(devOut(4'h2), 32'h00000000);
      autoPowerdown <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(devOut(4'h2), 32'h00000003);
      autoPowerdown <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(devOut(4'h2), 32'h00000000);
      wrapUp();
   end
endmodule : synth_divider_power_regs_test
`default_nettype wire
